// *** dv/tb_top.sv ***
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  import aer_regs_pkg::*;
  typedef struct {logic wr; logic [11:0] a; logic [31:0] d; logic [31:0] exp; logic err;} row_t;
  localparam logic [127:0] HDR = 128'h0123_4567_89AB_CDEF_FEDC_BA98_7654_3210;
  logic clk = 1'h0;
  logic rst = 1'h1;
  logic warm_rst = 1'h0;
  logic psel = 1'h0;
  logic penable = 1'h0;
  logic pwrite = 1'h0;
  logic [ADDR_W-1:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [31:0] cor_event = 32'h0;
  logic uncor_log_valid = 1'h0;
  logic [PTR_W-1:0] uncor_first_pos = 5'h00;
  logic [127:0] uncor_header = 128'h0;
  logic cor_err_report;
  logic crc_check_enable;
  logic crc_generate_enable;
  logic [31:0] rd_val;
  logic err_v;
  int n_fail = 0;
  int n_checks = 0;
  int bits [6] = '{BIT_ADVISORY_NONFATAL, BIT_REPLAY_TIMEOUT, BIT_REPLAY_ROLLOVER,
                   BIT_BAD_LINK_PACKET, BIT_BAD_TRANS_PACKET, BIT_RECEIVER_ERROR};
  row_t rows [$] = '{
    '{1'h0, OFF_COR_MASK, 32'h0, COR_MASK_RESET, 1'h0},
    '{1'h0, OFF_CAP_CTRL, 32'h0, 32'h0000_00A0, 1'h0},
    '{1'h0, OFF_COR_STATUS, 32'h0, 32'h0, 1'h0},
    '{1'h0, OFF_HDR_LOG1, 32'h0, 32'h0, 1'h0},
    '{1'h0, OFF_HDR_LOG2, 32'h0, 32'h0, 1'h0},
    '{1'h0, OFF_HDR_LOG3, 32'h0, 32'h0, 1'h0},
    '{1'h0, OFF_HDR_LOG4, 32'h0, 32'h0, 1'h0},
    '{1'h0, 12'h12C, 32'h0, 32'h0, 1'h1},
    '{1'h1, OFF_COR_MASK, 32'hFFFF_FFFF, 32'h0, 1'h0},
    '{1'h0, OFF_COR_MASK, 32'h0, COR_DEFINED, 1'h0},
    '{1'h1, OFF_CAP_CTRL, 32'hFFFF_FFFF, 32'h0, 1'h0},
    '{1'h0, OFF_CAP_CTRL, 32'h0, 32'h0000_01E0, 1'h0},
    '{1'h1, OFF_HDR_LOG1, 32'hFFFF_FFFF, 32'h0, 1'h0},
    '{1'h0, OFF_HDR_LOG1, 32'h0, 32'h0, 1'h0},
    '{1'h1, 12'h12C, 32'hFFFF_FFFF, 32'h0, 1'h1},
    '{1'h1, OFF_COR_MASK, 32'h0, 32'h0, 1'h0},
    '{1'h0, OFF_COR_MASK, 32'h0, 32'h0, 1'h0},
    '{1'h1, OFF_CAP_CTRL, 32'h0, 32'h0, 1'h0},
    '{1'h0, OFF_CAP_CTRL, 32'h0, 32'h0000_00A0, 1'h0}
  };

  aer_mask_ecrc_header_log i_dut (
    .clk(clk), .rst(rst), .warm_rst(warm_rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .cor_event(cor_event), .uncor_log_valid(uncor_log_valid),
    .uncor_first_pos(uncor_first_pos), .uncor_header(uncor_header),
    .cor_err_report(cor_err_report), .crc_check_enable(crc_check_enable),
    .crc_generate_enable(crc_generate_enable)
  );

  always #2 clk = ~clk;

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : report_and_stop

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // one apb transfer; request held until the edge that samples pready high
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int i;
    @(posedge clk);
    psel <= 1'h1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'h1;
    i = 0;
    do begin
      @(posedge clk);
      i++;
    end while (pready !== 1'h1 && i < 20);
    if (pready !== 1'h1) begin
      n_fail++;
      $display("wrong value at %0t: no pready", $time);
      report_and_stop();
    end else begin
      rd_val = prdata;
      err_v = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
    end
  endtask : apb

  task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
    apb(1'h0, a, 32'h0);
    check(rd_val, exp);
  endtask : rd_chk

  // one-cycle event pulse, ends in the cycle where the report should show
  task automatic pulse(input logic [31:0] ev);
    @(posedge clk);
    cor_event <= ev;
    @(posedge clk);
    cor_event <= 32'h0;
    @(negedge clk);
  endtask : pulse

  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'h0;
    foreach (rows[k]) begin
      apb(rows[k].wr, rows[k].a, rows[k].d);
      if (!rows[k].wr) check(rd_val, rows[k].exp);
      check(err_v, rows[k].err);
    end
    // unmasked events report one cycle later, for one cycle
    foreach (bits[k]) begin
      pulse(32'h1 << bits[k]);
      check(cor_err_report, 32'h1);
      @(negedge clk);
      check(cor_err_report, 32'h0);
    end
    rd_chk(OFF_COR_STATUS, COR_DEFINED);
    apb(1'h1, OFF_COR_MASK, COR_DEFINED);
    pulse(COR_DEFINED);
    check(cor_err_report, 32'h0);
    apb(1'h1, OFF_COR_STATUS, 32'h0000_0041);
    rd_chk(OFF_COR_STATUS, 32'h0000_3180);
    apb(1'h1, OFF_CAP_CTRL, 32'h0000_0140);
    @(negedge clk);
    check(crc_check_enable, 32'h1);
    check(crc_generate_enable, 32'h1);
    apb(1'h1, OFF_CAP_CTRL, 32'h0000_0100);
    @(negedge clk);
    check(crc_generate_enable, 32'h0);
    // header and first-error capture
    @(posedge clk);
    uncor_header <= HDR;
    uncor_first_pos <= 5'h15;
    uncor_log_valid <= 1'h1;
    @(posedge clk);
    uncor_log_valid <= 1'h0;
    for (int w = 0; w < 4; w++) begin
      rd_chk(OFF_HDR_LOG1 + 12'(4 * w), HDR[127 - 32 * w -: 32]);
    end
    rd_chk(OFF_CAP_CTRL, 32'h0000_01B5);
    // warm reset keeps sticky fields
    @(posedge clk);
    warm_rst <= 1'h1;
    @(posedge clk);
    warm_rst <= 1'h0;
    @(negedge clk);
    check(crc_check_enable, 32'h1);
    rd_chk(OFF_COR_MASK, COR_DEFINED);
    rd_chk(OFF_CAP_CTRL, 32'h0000_01B5);
    rd_chk(OFF_HDR_LOG1, HDR[127:96]);
    rd_chk(OFF_COR_STATUS, 32'h0000_3180);
    // power-on reset returns every field to its reset value
    @(posedge clk);
    rst <= 1'h1;
    repeat (2) @(posedge clk);
    rst <= 1'h0;
    @(negedge clk);
    check(crc_check_enable, 32'h0);
    rd_chk(OFF_COR_MASK, COR_MASK_RESET);
    rd_chk(OFF_CAP_CTRL, 32'h0000_00A0);
    rd_chk(OFF_HDR_LOG4, 32'h0);
    rd_chk(OFF_COR_STATUS, 32'h0);
    report_and_stop();
  end
endmodule : tb_top
`default_nettype wire

// *** logic/aer_mask_ecrc_header_log.sv ***
// Our own choice: the APB register port.
`timescale 1ns/100ps
`default_nettype none
// Contract
// - mask register at 0x114; advisory non-fatal mask bit 13 writable, sticky, resets one.
// - mask bits 12, 8, 7, 6, 0 writable, sticky, reset zero.
// - control bit 8 enables received-packet CRC checking; sticky, resets zero.
// - control bit 7 reads one always, check capability.
// - control bit 6 enables transmit CRC generation; sticky writable, resets zero.
// - control bit 5 reads one always, generation capability.
// - bits 4:0 sticky read-only first uncorrectable error position, reset zero.
// - packet header captured into four sticky read-only words from 0x11C, reset zero.
// - each masked condition has sticky status bit at 0x110, cleared by writing one.
module aer_mask_ecrc_header_log
  import aer_regs_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic warm_rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [31:0] cor_event,
  input wire logic uncor_log_valid,
  input wire logic [PTR_W-1:0] uncor_first_pos,
  input wire logic [127:0] uncor_header,
  output logic cor_err_report,
  output logic crc_check_enable,
  output logic crc_generate_enable
);
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_WAIT = 2'b01,
    ST_DONE = 2'b10
  } apb_state_t;

  apb_state_t state_q;
  logic [31:0] cor_status_q;
  logic [31:0] cor_mask_q;
  logic [PTR_W-1:0] first_error_pointer_q;
  logic [31:0] rd_value;
  logic [11:0] hdr_offset;
  logic wr_commit;
  logic [31:0] new_events;

  hdr_log_if hl ();

  header_log_store #(
    .WORDS(HDR_WORDS)
  ) u_store (
    .clk(clk),
    .rst(rst),
    .hl(hl)
  );

  function automatic logic hdr_hit(input logic [ADDR_W-1:0] a);
    return (a == OFF_HDR_LOG1) || (a == OFF_HDR_LOG2) ||
           (a == OFF_HDR_LOG3) || (a == OFF_HDR_LOG4);
  endfunction : hdr_hit

  function automatic logic reg_hit(input logic [ADDR_W-1:0] a);
    return (a == OFF_COR_STATUS) || (a == OFF_COR_MASK) ||
           (a == OFF_CAP_CTRL) || hdr_hit(a);
  endfunction : reg_hit

  assign wr_commit = psel && penable && pready && pwrite && !warm_rst;
  assign new_events = cor_event & COR_DEFINED;
  assign hdr_offset = paddr - OFF_HDR_LOG1;

  // header store: captured on each logged uncorrectable error
  assign hl.wr_en = uncor_log_valid;
  assign hl.wr_hdr = uncor_header;
  assign hl.rd_idx = hdr_offset[3:2];

  // apb handshake; pready comes two cycles after the setup cycle
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_q <= ST_IDLE;
      pready <= 1'b0;
    end else if (warm_rst) begin
      state_q <= ST_IDLE;
      pready <= 1'b0;
    end else begin
      unique case (state_q)
        ST_IDLE: begin
          if (psel && !penable) begin
            state_q <= ST_WAIT;
          end
        end
        ST_WAIT: begin
          state_q <= ST_DONE;
          pready <= 1'b1;
        end
        ST_DONE: begin
          state_q <= ST_IDLE;
          pready <= 1'b0;
        end
        default: begin
          state_q <= ST_IDLE;
          pready <= 1'b0;
        end
      endcase
    end
  end

  // read mux, reserved bits zero
  always_comb begin
    rd_value = RD_ZERO;
    if (paddr == OFF_COR_STATUS) begin
      rd_value = cor_status_q;
    end else if (paddr == OFF_COR_MASK) begin
      rd_value = cor_mask_q;
    end else if (paddr == OFF_CAP_CTRL) begin
      rd_value[BIT_CRC_CHECK_ENABLE] = crc_check_enable;
      rd_value[BIT_CRC_CHECK_CAPABLE] = 1'b1;
      rd_value[BIT_CRC_GENERATE_ENABLE] = crc_generate_enable;
      rd_value[BIT_CRC_GENERATE_CAPABLE] = 1'b1;
      rd_value[PTR_W-1:0] = first_error_pointer_q;
    end else if (hdr_hit(paddr)) begin
      rd_value = hl.rd_data;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      prdata <= RD_ZERO;
      pslverr <= 1'b0;
    end else if (warm_rst) begin
      prdata <= RD_ZERO;
      pslverr <= 1'b0;
    end else if (state_q == ST_WAIT) begin
      prdata <= pwrite ? RD_ZERO : rd_value;
      pslverr <= !reg_hit(paddr);
    end else if (state_q == ST_DONE) begin
      prdata <= RD_ZERO;
      pslverr <= 1'b0;
    end
  end

  // mask register, power-on reset only
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cor_mask_q <= COR_MASK_RESET;
    end else if (wr_commit && paddr == OFF_COR_MASK) begin
      cor_mask_q <= pwdata & COR_DEFINED;
    end
  end

  // status: hardware set wins over a write-one clear in the same cycle
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cor_status_q <= COR_STATUS_RESET;
    end else if (wr_commit && paddr == OFF_COR_STATUS) begin
      cor_status_q <= (cor_status_q & ~pwdata) | new_events;
    end else begin
      cor_status_q <= cor_status_q | new_events;
    end
  end

  // crc control bits, power-on reset only
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      crc_check_enable <= 1'b0;
      crc_generate_enable <= 1'b0;
    end else if (wr_commit && paddr == OFF_CAP_CTRL) begin
      crc_check_enable <= pwdata[BIT_CRC_CHECK_ENABLE];
      crc_generate_enable <= pwdata[BIT_CRC_GENERATE_ENABLE];
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      first_error_pointer_q <= FIRST_PTR_RESET;
    end else if (uncor_log_valid) begin
      first_error_pointer_q <= uncor_first_pos;
    end
  end

  // report only unmasked correctable errors
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cor_err_report <= 1'b0;
    end else if (warm_rst) begin
      cor_err_report <= 1'b0;
    end else begin
      cor_err_report <= |(new_events & ~cor_mask_q);
    end
  end

  // helper shadow for header readback checks
  logic [31:0] shadow_hdr1_q;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      shadow_hdr1_q <= HDR_WORD_RESET;
    end else if (uncor_log_valid) begin
      shadow_hdr1_q <= uncor_header[127:96];
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  a_advisory_mask_write: assert property (
    (wr_commit && paddr == OFF_COR_MASK)
    |=> cor_mask_q[BIT_ADVISORY_NONFATAL] == $past(pwdata[BIT_ADVISORY_NONFATAL]))
    else $error("advisory mask bit did not take written value");

  a_low_mask_write: assert property (
    (wr_commit && paddr == OFF_COR_MASK)
    |=> cor_mask_q == ($past(pwdata) & COR_DEFINED))
    else $error("mask register did not take written value");

  a_check_en_write: assert property (
    (wr_commit && paddr == OFF_CAP_CTRL)
    |=> crc_check_enable == $past(pwdata[BIT_CRC_CHECK_ENABLE]))
    else $error("crc check enable did not follow write");

  a_capable_read: assert property (
    (psel && penable && pready && !pwrite && paddr == OFF_CAP_CTRL)
    |-> prdata[BIT_CRC_CHECK_CAPABLE] && !pslverr)
    else $error("check capable bit did not read one");

  a_gen_en_write: assert property (
    (wr_commit && paddr == OFF_CAP_CTRL)
    |=> crc_generate_enable == $past(pwdata[BIT_CRC_GENERATE_ENABLE]))
    else $error("crc generate enable did not follow write");

  a_gen_cap_read: assert property (
    (psel && penable && pready && !pwrite && paddr == OFF_CAP_CTRL)
    |-> prdata[BIT_CRC_GENERATE_CAPABLE] && prdata[31:9] == 23'h000000)
    else $error("generate capable bit did not read one");

  a_pointer_capture: assert property (
    uncor_log_valid |=> first_error_pointer_q == $past(uncor_first_pos))
    else $error("first error pointer not captured");

  a_header_readback: assert property (
    (psel && penable && pready && !pwrite && paddr == OFF_HDR_LOG1
     && !$past(uncor_log_valid) && !$past(uncor_log_valid, 2))
    |-> prdata == shadow_hdr1_q)
    else $error("header word one readback mismatch");

  a_status_set_wins: assert property (
    (new_events != 32'h0000_0000)
    |=> (cor_status_q & $past(new_events)) == $past(new_events))
    else $error("correctable event lost from status");

  a_status_clear: assert property (
    (wr_commit && paddr == OFF_COR_STATUS && new_events == 32'h0000_0000)
    |=> (cor_status_q & $past(pwdata)) == 32'h0000_0000)
    else $error("write one did not clear status");

  a_report_masked: assert property (
    cor_err_report |-> ($past(new_events) & ~$past(cor_mask_q)) != 32'h0000_0000)
    else $error("report raised for masked or absent error");

  a_report_unmasked: assert property (
    (|(new_events & ~cor_mask_q) && !warm_rst) |=> cor_err_report)
    else $error("unmasked error not reported");

  a_sticky_warm: assert property (
    warm_rst |=> $stable(cor_mask_q) && $stable(crc_check_enable))
    else $error("sticky field changed on warm reset");

  a_ready_timing: assert property (
    disable iff (rst || warm_rst)
    (psel && !penable && state_q == ST_IDLE) |=> !pready ##1 pready ##1 !pready)
    else $error("apb answer not two cycles after setup");

  a_unmapped_slverr: assert property (
    (psel && penable && pready && !reg_hit(paddr))
    |-> pslverr && prdata == RD_ZERO)
    else $error("unmapped access not refused");

  a_mapped_no_error: assert property (
    (psel && penable && pready && reg_hit(paddr))
    |-> !pslverr)
    else $error("mapped access flagged as error");

  a_ready_pulse: assert property (
    pready
    |=> !pready)
    else $error("pready held longer than one cycle");

  a_idle_outputs_zero: assert property (
    !pready
    |-> prdata == RD_ZERO && !pslverr)
    else $error("read data or error shown outside answer cycle");

  a_mask_hold: assert property (
    !(wr_commit && paddr == OFF_COR_MASK)
    |=> $stable(cor_mask_q))
    else $error("mask register changed without a write");

  a_ctrl_hold: assert property (
    !(wr_commit && paddr == OFF_CAP_CTRL)
    |=> $stable(crc_check_enable) && $stable(crc_generate_enable))
    else $error("crc enable changed without a write");

  a_pointer_hold: assert property (
    !uncor_log_valid
    |=> $stable(first_error_pointer_q))
    else $error("first error pointer changed without a capture");

  a_status_hold: assert property (
    (new_events == 32'h0000_0000 && !(wr_commit && paddr == OFF_COR_STATUS))
    |=> $stable(cor_status_q))
    else $error("status changed without event or clear");

  a_warm_clears: assert property (
    warm_rst
    |=> !pready && !pslverr && !cor_err_report && prdata == RD_ZERO)
    else $error("warm reset left bus or report output set");

  a_masked_silent: assert property (
    ((new_events & ~cor_mask_q) == 32'h0000_0000)
    |=> !cor_err_report)
    else $error("report raised without an unmasked event");

  a_enable_readback: assert property (
    (psel && penable && pready && !pwrite && paddr == OFF_CAP_CTRL)
    |-> prdata[BIT_CRC_CHECK_ENABLE] == crc_check_enable
        && prdata[BIT_CRC_GENERATE_ENABLE] == crc_generate_enable)
    else $error("crc enable bits read back wrong");

  a_mask_readback: assert property (
    (psel && penable && pready && !pwrite && paddr == OFF_COR_MASK)
    |-> prdata == cor_mask_q)
    else $error("mask register read back wrong");

  c_mask_write: cover property (wr_commit && paddr == OFF_COR_MASK);
  c_status_clear_race: cover property (
    wr_commit && paddr == OFF_COR_STATUS && (new_events & pwdata) != 32'h0000_0000);
  c_header_read: cover property (psel && penable && pready && paddr == OFF_HDR_LOG3);
  c_unmapped: cover property (pready && pslverr);
  c_masked_event: cover property (new_events != 32'h0000_0000 && (new_events & ~cor_mask_q) == 32'h0000_0000);
endmodule : aer_mask_ecrc_header_log
`default_nettype wire

// *** logic/aer_regs_pkg.sv ***
`default_nettype none
package aer_regs_pkg;
  localparam int ADDR_W = 12;
  localparam logic [11:0] OFF_COR_STATUS = 12'h110;
  localparam logic [11:0] OFF_COR_MASK = 12'h114;
  localparam logic [11:0] OFF_CAP_CTRL = 12'h118;
  localparam logic [11:0] OFF_HDR_LOG1 = 12'h11C;
  localparam logic [11:0] OFF_HDR_LOG2 = 12'h120;
  localparam logic [11:0] OFF_HDR_LOG3 = 12'h124;
  localparam logic [11:0] OFF_HDR_LOG4 = 12'h128;
  // correctable error bit positions, shared by status and mask
  localparam int BIT_ADVISORY_NONFATAL = 13;
  localparam int BIT_REPLAY_TIMEOUT = 12;
  localparam int BIT_REPLAY_ROLLOVER = 8;
  localparam int BIT_BAD_LINK_PACKET = 7;
  localparam int BIT_BAD_TRANS_PACKET = 6;
  localparam int BIT_RECEIVER_ERROR = 0;
  localparam logic [31:0] COR_DEFINED = 32'h0000_31C1;
  localparam logic [31:0] COR_MASK_RESET = 32'h0000_2000;
  localparam logic [31:0] COR_STATUS_RESET = 32'h0000_0000;
  // capabilities and control fields
  localparam int BIT_CRC_CHECK_ENABLE = 8;
  localparam int BIT_CRC_CHECK_CAPABLE = 7;
  localparam int BIT_CRC_GENERATE_ENABLE = 6;
  localparam int BIT_CRC_GENERATE_CAPABLE = 5;
  localparam int PTR_W = 5;
  localparam logic [PTR_W-1:0] FIRST_PTR_RESET = 5'h00;
  localparam int HDR_WORDS = 4;
  localparam logic [31:0] HDR_WORD_RESET = 32'h0000_0000;
  localparam logic [31:0] RD_ZERO = 32'h0000_0000;
endpackage : aer_regs_pkg
`default_nettype wire

// *** logic/hdr_log_if.sv ***
`timescale 1ns/100ps
`default_nettype none
interface hdr_log_if;
  logic wr_en;
  logic [127:0] wr_hdr;
  logic [1:0] rd_idx;
  logic [31:0] rd_data;
  modport owner (output wr_en, output wr_hdr, output rd_idx, input rd_data);
  modport store (input wr_en, input wr_hdr, input rd_idx, output rd_data);
endinterface : hdr_log_if
`default_nettype wire

// *** logic/header_log_store.sv ***
`timescale 1ns/100ps
`default_nettype none
module header_log_store
  import aer_regs_pkg::*;
#(
  parameter int WORDS = HDR_WORDS
) (
  input wire logic clk,
  input wire logic rst,
  hdr_log_if.store hl
);
  logic [31:0] word_q [WORDS];

  // word 0 holds header bits 127:96, the last word bits 31:0; power-on reset only
  for (genvar i = 0; i < WORDS; i++) begin : g_word
    always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
        word_q[i] <= HDR_WORD_RESET;
      end else if (hl.wr_en) begin
        word_q[i] <= hl.wr_hdr[128-32*i-1 -: 32];
      end
    end
  end

  // registered read port
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      hl.rd_data <= HDR_WORD_RESET;
    end else begin
      hl.rd_data <= word_q[hl.rd_idx];
    end
  end
endmodule : header_log_store
`default_nettype wire
